// ==== mdc_pkg.sv ====
package mdc_pkg;
	// ----------------------------------------------------------------
	// Selection codes
	// ----------------------------------------------------------------
	localparam logic [1:0] ROUTE_A       = 2'h1;
	localparam logic [1:0] ROUTE_B       = 2'h2;
	localparam logic       TX_BURST      = 1'h1;
	localparam logic [1:0] PRE_32        = 2'h0;
	localparam logic [1:0] PRE_48        = 2'h1;
	localparam logic [1:0] PRE_64        = 2'h2;
	localparam logic [7:0] PRE_LEN_32    = 8'h20;
	localparam logic [7:0] PRE_LEN_48    = 8'h30;
	localparam logic [7:0] PRE_LEN_64    = 8'h40;
	localparam logic [1:0] CLK_RX        = 2'h0;
	localparam logic [1:0] CLK_EXT       = 2'h1;
	localparam logic [1:0] CLK_MOD       = 2'h2;
	localparam logic [1:0] OSC_SHARED    = 2'h1;
	localparam logic [1:0] OSC_ON        = 2'h2;
	localparam logic [2:0] SCR_IBS       = 3'h3;
	localparam logic [2:0] SCR_MAX       = 3'h4;
	localparam logic [1:0] DMX_MAX       = 2'h2;
	localparam logic [2:0] FMT_MAX       = 3'h5;
	// ----------------------------------------------------------------
	// Ranges and timing
	// ----------------------------------------------------------------
	localparam logic [21:0] RATE_MIN_BPS = 22'd3600;
	localparam logic [21:0] RATE_MAX_BPS = 22'd2100000;
	localparam logic [16:0] DEPTH_MIN    = 17'd4;
	localparam logic [16:0] DEPTH_MAX    = 17'd131070;
	localparam int          CLK_HZ       = 50000000;
	localparam int          PCT_FULL     = 200;
	localparam int          PCT_RESET    = 100;
	// Overhead channel rates, index 0 to 7.
	localparam int OSC_BAUD [8] = '{150, 300, 600, 1200, 2400, 4800,
		9600, 19200};
	typedef enum logic [1:0] {MDC_IDLE, MDC_PREAMBLE, MDC_SEND} mdc_tx_t;
endpackage

// ==== mdc_osc_timer.sv ====
module mdc_osc_timer #(
	parameter int CNT_W = 19
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic [2:0] rate_idx,
	output logic            bit_tick
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] div_w;

	function automatic logic [CNT_W-1:0] div_of(input logic [2:0] i);
		int d;
		d = mdc_pkg::CLK_HZ / mdc_pkg::OSC_BAUD[i];
		return CNT_W'(d - 1);
	endfunction

	initial begin
		if (CNT_W < 19)
			$error("CNT_W too small for the slowest rate.");
	end

	assign div_w = div_of(rate_idx);

	// Index picks the bit period of the overhead channel. [R9]
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r    <= '0;
			bit_tick <= 1'b0;
		end else if (cnt_r >= div_w) begin
			cnt_r    <= '0;
			bit_tick <= 1'b1;
		end else begin
			cnt_r    <= cnt_r + 1'b1;
			bit_tick <= 1'b0;
		end
	end
endmodule

// ==== mdc_datapath_cfg.sv ====
// What this block does
// [R1] Each alarm source has a 2-bit route: 0 none, 1 to A, 2 to B, 3 both.
// [R2] Transmit mode 0 is continuous and 1 is burst.
// [R3] In burst mode a preamble of 32, 48 or 64 symbols is sent per code.
// [R4] RTS action 0 ignores RTS and 1 lets RTS switch the carrier.
// [R5] Mute mode manual keeps the carrier off after a change until enabled.
// [R6] Clock source 0 receive, 1 external FIFO, 2 modulator; 0 bypasses FIFO.
// [R7] FIFO fill is reported 0-200 percent; 0 clears status, 1 re-centres.
// [R8] Overhead port mode 1 drives only while sending, 2 always, 0 single.
// [R9] Overhead rate index 0 to 7 picks 150 bps up to 19.2 kbps.
// [R10] Overhead format code 0 to 5 picks parity, data and stop bits.
// [R11] Receive data sense and clock phase each invert when their bit is 1.
// [R12] Descrambler 0 to 4; types 3 and 4 only with framing hardware.
// [R13] Demux 0 to 2 is available only with option hardware.
// [R14] Receive bit rate is 3600 to 2100000 bps in 1 bps steps.
// [R15] FIFO depth 4 to 131070 bits, rescaled on rate change for same delay.
// [R16] A summary alarm is on while any source routed to it is active.
// [R17] Re-centre resets the pointers so occupancy is half the depth.
module mdc_datapath_cfg #(
	parameter int NSRC = 5
) (
	input  wire logic            ref_clk,
	input  wire logic            rst_b,
	input  wire logic [NSRC-1:0] alarm_src,
	input  wire logic [2*NSRC-1:0] alarm_route,
	input  wire logic            tx_mode,
	input  wire logic [1:0]      preamble_code,
	input  wire logic            tx_start,
	input  wire logic            rts_action,
	input  wire logic            rts_in,
	input  wire logic            carrier_mute_mode,
	input  wire logic            mod_out_change,
	input  wire logic            carrier_enable,
	input  wire logic            tx_sym_tick,
	input  wire logic [1:0]      rx_clk_sel,
	input  wire logic            rx_data_in,
	input  wire logic            rx_data_inv,
	input  wire logic            rx_clk_inv,
	input  wire logic            fifo_cmd_valid,
	input  wire logic            fifo_cmd,
	input  wire logic            fifo_wr,
	input  wire logic            fifo_rd,
	input  wire logic [21:0]     rx_rate_bps,
	input  wire logic [16:0]     fifo_depth_set,
	input  wire logic [1:0]      osc_port_mode,
	input  wire logic [2:0]      osc_rate_idx,
	input  wire logic [2:0]      osc_format,
	input  wire logic            osc_sending,
	input  wire logic [2:0]      descr_sel,
	input  wire logic            framing_hw,
	input  wire logic [1:0]      demux_sel,
	input  wire logic            mux_hw,
	output logic                 alarm_a,
	output logic                 alarm_b,
	output logic                 carrier_on,
	output logic                 preamble_active,
	output logic                 fifo_bypass,
	output logic [1:0]           rx_clk_src,
	output logic                 rx_data_out,
	output logic                 rx_clk_phase,
	output logic [7:0]           fifo_fill_pct,
	output logic                 fifo_status_err,
	output logic [16:0]          fifo_depth,
	output logic [21:0]          rx_rate,
	output logic                 osc_tx_oe,
	output logic                 osc_rs485,
	output logic                 osc_bit_tick,
	output logic                 osc_parity_en,
	output logic                 osc_eight_bits,
	output logic                 osc_two_stop,
	output logic [2:0]           descr_type,
	output logic [1:0]           demux_type
);
	initial begin
		if (NSRC < 1)
			$error("NSRC must be at least one.");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic rts_s1_r;
	logic rts_s2_r;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rts_s1_r <= 1'b0;
			rts_s2_r <= 1'b0;
		end else begin
			rts_s1_r <= rts_in;
			rts_s2_r <= rts_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Alarm routing
	// ----------------------------------------------------------------
	function automatic logic routed(input logic [NSRC-1:0] src,
		input logic [2*NSRC-1:0] rt, input logic [1:0] dst);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < NSRC; i++)
			hit = hit | (src[i] & |(rt[2*i +: 2] & dst));
		return hit;
	endfunction

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			alarm_a <= 1'b0;
			alarm_b <= 1'b0;
		end else begin
			alarm_a <= routed(alarm_src, alarm_route, mdc_pkg::ROUTE_A); // [R1] [R16]
			alarm_b <= routed(alarm_src, alarm_route, mdc_pkg::ROUTE_B); // [R1] [R16]
		end
	end

	// ----------------------------------------------------------------
	// Transmit carrier and preamble
	// ----------------------------------------------------------------
	logic          muted_r;
	logic          carrier_want;
	logic [7:0]    pre_cnt_r;
	logic [7:0]    pre_len;
	mdc_pkg::mdc_tx_t tx_st_r;

	always_comb begin
		unique case (preamble_code)
			mdc_pkg::PRE_32: pre_len = mdc_pkg::PRE_LEN_32; // [R3]
			mdc_pkg::PRE_48: pre_len = mdc_pkg::PRE_LEN_48; // [R3]
			default:         pre_len = mdc_pkg::PRE_LEN_64; // [R3]
		endcase
	end

	// Manual mute latches off on any output change; set beats clear.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			muted_r <= 1'b0;
		else if (mod_out_change && !carrier_mute_mode)
			muted_r <= 1'b1; // [R5]
		else if (carrier_enable || carrier_mute_mode)
			muted_r <= 1'b0; // [R5]
	end

	assign carrier_want = !muted_r && !mod_out_change &&
		(!rts_action || rts_s2_r); // [R4] [R5]

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_r   <= mdc_pkg::MDC_IDLE;
			pre_cnt_r <= '0;
		end else begin
			unique case (tx_st_r)
				mdc_pkg::MDC_IDLE:
					if (carrier_want && tx_mode == mdc_pkg::TX_BURST &&
						tx_start) begin
						tx_st_r   <= mdc_pkg::MDC_PREAMBLE; // [R2]
						pre_cnt_r <= '0;
					end else if (carrier_want &&
						tx_mode != mdc_pkg::TX_BURST) begin
						tx_st_r <= mdc_pkg::MDC_SEND; // [R2]
					end
				mdc_pkg::MDC_PREAMBLE:
					if (!carrier_want)
						tx_st_r <= mdc_pkg::MDC_IDLE;
					else if (tx_sym_tick) begin
						if (pre_cnt_r == pre_len - 8'h01)
							tx_st_r <= mdc_pkg::MDC_SEND; // [R3]
						pre_cnt_r <= pre_cnt_r + 8'h01;
					end
				mdc_pkg::MDC_SEND:
					if (!carrier_want)
						tx_st_r <= mdc_pkg::MDC_IDLE;
				default:
					tx_st_r <= mdc_pkg::MDC_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			carrier_on      <= 1'b0;
			preamble_active <= 1'b0;
		end else begin
			carrier_on      <= carrier_want && tx_st_r != mdc_pkg::MDC_IDLE;
			preamble_active <= tx_st_r == mdc_pkg::MDC_PREAMBLE; // [R3]
		end
	end

	// ----------------------------------------------------------------
	// Receive output path
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_clk_src   <= mdc_pkg::CLK_RX;
			fifo_bypass  <= 1'b1;
			rx_data_out  <= 1'b0;
			rx_clk_phase <= 1'b0;
			descr_type   <= '0;
			demux_type   <= '0;
			rx_rate      <= mdc_pkg::RATE_MIN_BPS;
		end else begin
			// Code 3 is not a source; the last legal choice is kept.
			if (rx_clk_sel <= mdc_pkg::CLK_MOD) begin
				rx_clk_src  <= rx_clk_sel; // [R6]
				fifo_bypass <= rx_clk_sel == mdc_pkg::CLK_RX; // [R6]
			end
			rx_data_out  <= rx_data_in ^ rx_data_inv; // [R11]
			rx_clk_phase <= rx_clk_inv; // [R11]
			if (descr_sel <= mdc_pkg::SCR_MAX &&
				(descr_sel < mdc_pkg::SCR_IBS || framing_hw))
				descr_type <= descr_sel; // [R12]
			else if (!framing_hw && descr_type >= mdc_pkg::SCR_IBS)
				descr_type <= '0; // [R12]
			if (!mux_hw)
				demux_type <= '0; // [R13]
			else if (demux_sel <= mdc_pkg::DMX_MAX)
				demux_type <= demux_sel; // [R13]
			if (rx_rate_bps >= mdc_pkg::RATE_MIN_BPS &&
				rx_rate_bps <= mdc_pkg::RATE_MAX_BPS)
				rx_rate <= rx_rate_bps; // [R14]
		end
	end

	// ----------------------------------------------------------------
	// FIFO depth and fill
	// ----------------------------------------------------------------
	logic [16:0] occ_r;
	logic [21:0] rate_prev_r;
	logic [16:0] scaled;

	// Keeps delay constant: new depth = old depth * new rate / old rate.
	// The divider is wide but its result is only used on a rate change.
	function automatic logic [16:0] clamp_depth(input logic [39:0] d);
		if (d < 40'(mdc_pkg::DEPTH_MIN))
			return mdc_pkg::DEPTH_MIN;
		else if (d > 40'(mdc_pkg::DEPTH_MAX))
			return mdc_pkg::DEPTH_MAX;
		return d[16:0];
	endfunction

	assign scaled = clamp_depth((40'(fifo_depth) * 40'(rx_rate)) /
		40'(rate_prev_r));

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			fifo_depth  <= mdc_pkg::DEPTH_MAX;
			rate_prev_r <= mdc_pkg::RATE_MIN_BPS;
		end else begin
			rate_prev_r <= rx_rate;
			if (rx_rate != rate_prev_r)
				fifo_depth <= scaled; // [R15]
			else if (fifo_depth_set != fifo_depth &&
				fifo_depth_set >= mdc_pkg::DEPTH_MIN &&
				fifo_depth_set <= mdc_pkg::DEPTH_MAX)
				fifo_depth <= fifo_depth_set; // [R15]
		end
	end

	// Occupancy model of the delay FIFO; bypass leaves it idle.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			occ_r <= mdc_pkg::DEPTH_MAX >> 1;
		else if (fifo_cmd_valid && fifo_cmd)
			occ_r <= fifo_depth >> 1; // [R17]
		else if (occ_r > fifo_depth)
			occ_r <= fifo_depth; // [R15]
		else if (!fifo_bypass) begin
			if (fifo_wr && !fifo_rd && occ_r < fifo_depth)
				occ_r <= occ_r + 17'h00001;
			else if (fifo_rd && !fifo_wr && occ_r != '0)
				occ_r <= occ_r - 17'h00001;
		end
	end

	// Underflow or overflow sticks until cleared; a new fault wins.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			fifo_fill_pct   <= 8'(mdc_pkg::PCT_RESET);
			fifo_status_err <= 1'b0;
		end else begin
			// A shrunk depth can leave occupancy above it for a cycle.
			if (occ_r >= fifo_depth)
				fifo_fill_pct <= 8'(mdc_pkg::PCT_FULL); // [R7]
			else
				fifo_fill_pct <= 8'((40'(occ_r) * 40'(mdc_pkg::PCT_FULL)) /
					40'(fifo_depth)); // [R7]
			if (!fifo_bypass && ((fifo_rd && occ_r == '0) ||
				(fifo_wr && occ_r >= fifo_depth)))
				fifo_status_err <= 1'b1; // [R7]
			else if (fifo_cmd_valid && !fifo_cmd)
				fifo_status_err <= 1'b0; // [R7]
		end
	end

	// ----------------------------------------------------------------
	// Overhead serial channel
	// ----------------------------------------------------------------
	logic tick_w;

	mdc_osc_timer u_timer (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.rate_idx (osc_rate_idx),
		.bit_tick (tick_w)
	);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			osc_tx_oe      <= 1'b1;
			osc_rs485      <= 1'b0;
			osc_bit_tick   <= 1'b0;
			osc_parity_en  <= 1'b0;
			osc_eight_bits <= 1'b1;
			osc_two_stop   <= 1'b0;
		end else begin
			osc_bit_tick <= tick_w; // [R9]
			osc_rs485    <= osc_port_mode != 2'h0; // [R8]
			osc_tx_oe    <= osc_port_mode == mdc_pkg::OSC_SHARED ?
				osc_sending : 1'b1; // [R8]
			if (osc_format <= mdc_pkg::FMT_MAX) begin
				osc_parity_en  <= osc_format inside {3'h1, 3'h2, 3'h5}; // [R10]
				osc_eight_bits <= osc_format >= 3'h3; // [R10]
				osc_two_stop   <= osc_format inside {3'h0, 3'h2, 3'h4}; // [R10]
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_alarm_a;
		@(posedge ref_clk) disable iff (!rst_b)
		1'b1 |=> alarm_a == $past(routed(alarm_src, alarm_route,
			mdc_pkg::ROUTE_A));
	endproperty
	a_alarm_a: assert property (p_alarm_a) else $error("alarm A wrong"); // [R16]

	property p_bypass;
		@(posedge ref_clk) disable iff (!rst_b)
		rx_clk_sel == mdc_pkg::CLK_RX |=> fifo_bypass;
	endproperty
	a_bypass: assert property (p_bypass) else $error("no bypass"); // [R6]

	property p_rts;
		@(posedge ref_clk) disable iff (!rst_b)
		rts_action && !rts_s2_r |=> !carrier_on;
	endproperty
	a_rts: assert property (p_rts) else $error("RTS ignored"); // [R4]

	sequence s_change_manual;
		mod_out_change && !carrier_mute_mode;
	endsequence
	property p_mute;
		@(posedge ref_clk) disable iff (!rst_b)
		s_change_manual ##1 !carrier_enable |=> !carrier_on;
	endproperty
	a_mute: assert property (p_mute) else $error("mute lost"); // [R5]

	property p_recentre;
		@(posedge ref_clk) disable iff (!rst_b)
		fifo_cmd_valid && fifo_cmd |=> occ_r == ($past(fifo_depth) >> 1);
	endproperty
	a_recentre: assert property (p_recentre) else $error("recentre"); // [R17]

	property p_pct;
		@(posedge ref_clk) disable iff (!rst_b)
		fifo_fill_pct <= 8'(mdc_pkg::PCT_FULL);
	endproperty
	a_pct: assert property (p_pct) else $error("fill over 200"); // [R7]

	property p_descr;
		@(posedge ref_clk) disable iff (!rst_b)
		!framing_hw && $stable(framing_hw) |-> descr_type < mdc_pkg::SCR_IBS;
	endproperty
	a_descr: assert property (p_descr) else $error("descr no hw"); // [R12]

	property p_depth;
		@(posedge ref_clk) disable iff (!rst_b)
		fifo_depth >= mdc_pkg::DEPTH_MIN && fifo_depth <= mdc_pkg::DEPTH_MAX;
	endproperty
	a_depth: assert property (p_depth) else $error("depth range"); // [R15]

	property p_oe;
		@(posedge ref_clk) disable iff (!rst_b)
		osc_port_mode == mdc_pkg::OSC_ON |=> osc_tx_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("port not driven"); // [R8]
endmodule

// ==== mdc_dte_model.sv ====
module mdc_dte_model (
	input  wire logic ref_clk,
	input  wire logic rts_req,
	output logic      rts_in,
	output logic      rx_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Terminal side of the data interface
	// ----------------------------------------------------------------
	logic [7:0] pat_r;
	initial begin
		pat_r = 8'ha5;
		rts_in = 1'b0;
		rx_data_in = 1'b0;
	end
	// The terminal has no clock of ours, so its pin moves off the grid.
	always @(rts_req) rts_in <= #7 rts_req;
	always @(posedge ref_clk) begin
		pat_r <= #1 {pat_r[6:0], pat_r[7] ^ pat_r[5] ^ pat_r[0]};
		rx_data_in <= #1 pat_r[7];
	end
endmodule

// ==== modem_datapath_config_tb.sv ====
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	error_cnt++; $display("wrong value %s exp %0h got %0h", n, e, g); end end

module modem_datapath_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        ref_clk, rst_b, tx_mode, tx_start, rts_action, rts_req;
	logic        carrier_mute_mode, mod_out_change, carrier_enable;
	logic        tx_sym_tick, rx_data_inv, rx_clk_inv, fifo_cmd_valid;
	logic        fifo_cmd, fifo_wr, fifo_rd, osc_sending, framing_hw, mux_hw;
	logic [4:0]  alarm_src;
	logic [9:0]  alarm_route;
	logic [1:0]  preamble_code, rx_clk_sel, osc_port_mode, demux_sel;
	logic [21:0] rx_rate_bps;
	logic [16:0] fifo_depth_set;
	logic [2:0]  osc_rate_idx, osc_format, descr_sel;
	logic        alarm_a, alarm_b, carrier_on, preamble_active, fifo_bypass;
	logic        rx_data_out, rx_clk_phase, fifo_status_err, osc_tx_oe;
	logic        osc_rs485, osc_bit_tick, osc_parity_en, osc_eight_bits;
	logic        osc_two_stop, rts_in, rx_data_in, ea, eb, d;
	logic [1:0]  rx_clk_src, demux_type, e2;
	logic [7:0]  fifo_fill_pct, epl;
	logic [16:0] fifo_depth;
	logic [21:0] rx_rate, er;
	logic [2:0]  descr_type, e3;
	logic [31:0] seed;
	int          error_cnt, samples_checked, i, j, n, p;
	int          rates [5] = '{3599, 3600, 2100000, 2100001, 3600};

	mdc_datapath_cfg mdc_datapath_cfg_inst (.ref_clk, .rst_b, .alarm_src,
		.alarm_route, .tx_mode, .preamble_code, .tx_start, .rts_action,
		.rts_in, .carrier_mute_mode, .mod_out_change, .carrier_enable,
		.tx_sym_tick, .rx_clk_sel, .rx_data_in, .rx_data_inv, .rx_clk_inv,
		.fifo_cmd_valid, .fifo_cmd, .fifo_wr, .fifo_rd, .rx_rate_bps,
		.fifo_depth_set, .osc_port_mode, .osc_rate_idx, .osc_format,
		.osc_sending, .descr_sel, .framing_hw, .demux_sel, .mux_hw,
		.alarm_a, .alarm_b, .carrier_on, .preamble_active, .fifo_bypass,
		.rx_clk_src, .rx_data_out, .rx_clk_phase, .fifo_fill_pct,
		.fifo_status_err, .fifo_depth, .rx_rate, .osc_tx_oe, .osc_rs485,
		.osc_bit_tick, .osc_parity_en, .osc_eight_bits, .osc_two_stop,
		.descr_type, .demux_type);
	mdc_dte_model mdc_dte_model_inst (.ref_clk, .rts_req, .rts_in,
		.rx_data_in);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#2;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask
	task automatic fcmd(input logic c);
		fifo_cmd = c;
		pulse(fifo_cmd_valid);
		step(3);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Waits for the next tick; a stuck tick must not hang the run.
	task automatic tick_gap(output int g);
		g = 0;
		step(1);
		while (osc_bit_tick !== 1'b1) begin
			g++;
			step(1);
			if (g > 8000) begin
				error_cnt++;
				end_sim();
			end
		end
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		{alarm_src, alarm_route, tx_mode, preamble_code, tx_start} = '0;
		{rts_action, rts_req, mod_out_change, carrier_enable} = '0;
		{tx_sym_tick, rx_clk_sel, rx_data_inv, rx_clk_inv} = '0;
		{fifo_cmd_valid, fifo_cmd, fifo_wr, fifo_rd, rx_rate_bps} = '0;
		{fifo_depth_set, osc_port_mode, osc_rate_idx, osc_format} = '0;
		{osc_sending, descr_sel, framing_hw, demux_sel, mux_hw} = '0;
		carrier_mute_mode = 1'b1;
		seed = 32'he66a85fc;
		error_cnt = 0;
		samples_checked = 0;
		repeat (3) @(posedge ref_clk);
		#2;
		`CHK("fill", 8'(mdc_pkg::PCT_RESET), fifo_fill_pct);
		`CHK("depth", mdc_pkg::DEPTH_MAX, fifo_depth);
		`CHK("rate", mdc_pkg::RATE_MIN_BPS, rx_rate);
		rst_b = 1'b1;
		step(1);
		for (i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			alarm_src = (i == 23) ? 5'h0 : seed[4:0];
			alarm_route = seed[14:5];
			step(2);
			{ea, eb} = 2'h0;
			for (j = 0; j < 5; j++) begin
				ea |= alarm_src[j] & alarm_route[2*j];
				eb |= alarm_src[j] & alarm_route[2*j+1];
			end
			`CHK("alarm_a", ea, alarm_a);
			`CHK("alarm_b", eb, alarm_b);
		end
		for (i = 0; i < 4; i++) begin
			rx_clk_sel = 2'(i);
			{rx_clk_inv, rx_data_inv} = {2{i[0]}};
			step(2);
			`CHK("clk_src", 2'((i == 3) ? 2 : i), rx_clk_src);
			`CHK("bypass", 1'(i == 0), fifo_bypass);
			`CHK("clk_phase", i[0], rx_clk_phase);
			for (j = 0; j < 8; j++) begin
				d = rx_data_in;
				step(1);
				`CHK("data_out", d ^ i[0], rx_data_out);
			end
		end
		for (i = 0; i < 7; i++) begin
			osc_format = 3'(i);
			p = (i == 6) ? 5 : i;
			step(2);
			`CHK("parity", 1'(p == 1 || p == 2 || p == 5), osc_parity_en);
			`CHK("eight", 1'(p >= 3), osc_eight_bits);
			`CHK("two_stop", 1'(p % 2 == 0), osc_two_stop);
		end
		for (i = 0; i < 6; i++) begin
			osc_port_mode = 2'(i / 2);
			osc_sending = i[0];
			step(2);
			`CHK("rs485", 1'(i >= 2), osc_rs485);
			if (i >= 2)
				`CHK("tx_oe", 1'(i >= 4 || i == 3), osc_tx_oe);
		end
		for (i = 7; i > 5; i--) begin
			osc_rate_idx = 3'(i);
			tick_gap(n);
			tick_gap(n);
			p = mdc_pkg::CLK_HZ / mdc_pkg::OSC_BAUD[i];
			`CHK("osc_period", p - 1, n);
		end
		e3 = 3'h0;
		for (i = 0; i < 10; i++) begin
			framing_hw = 1'(i / 5);
			descr_sel = 3'(i % 5);
			step(2);
			if (i % 5 < 3 || i >= 5)
				e3 = 3'(i % 5);
			`CHK("descr", e3, descr_type);
		end
		framing_hw = 1'b0;
		step(2);
		`CHK("descr", 3'h0, descr_type);
		for (i = 0; i < 6; i++) begin
			mux_hw = 1'(i / 3);
			demux_sel = 2'(i % 3);
			step(2);
			`CHK("demux", 2'(mux_hw ? i % 3 : 0), demux_type);
		end
		er = mdc_pkg::RATE_MIN_BPS;
		for (i = 0; i < 5; i++) begin
			rx_rate_bps = 22'(rates[i]);
			step(4);
			if (rates[i] >= 3600 && rates[i] <= 2100000)
				er = 22'(rates[i]);
			`CHK("rx_rate", er, rx_rate);
		end
		// Occupancy stays away from the ends except where refusal is tested.
		rx_clk_sel = mdc_pkg::CLK_EXT;
		fifo_depth_set = 17'h3e8;
		step(3);
		`CHK("depth", 17'h3e8, fifo_depth);
		fifo_depth_set = 17'h0;
		fcmd(1'b1);
		`CHK("fill", 8'h64, fifo_fill_pct);
		fifo_wr = 1'b1;
		step(10);
		fifo_wr = 1'b0;
		step(3);
		`CHK("fill", 8'h66, fifo_fill_pct);
		fcmd(1'b1);
		`CHK("fill", 8'h64, fifo_fill_pct);
		fifo_rd = 1'b1;
		step(501);
		fifo_rd = 1'b0;
		step(3);
		`CHK("fill", 8'h0, fifo_fill_pct);
		`CHK("err", 1'b1, fifo_status_err);
		fcmd(1'b0);
		`CHK("err", 1'b0, fifo_status_err);
		rx_rate_bps = 22'h1c20;
		step(4);
		`CHK("depth", 17'h7d0, fifo_depth);
		carrier_mute_mode = 1'b0;
		pulse(carrier_enable);
		step(4);
		`CHK("carrier", 1'b1, carrier_on);
		pulse(mod_out_change);
		step(10);
		`CHK("carrier", 1'b0, carrier_on);
		pulse(carrier_enable);
		step(4);
		`CHK("carrier", 1'b1, carrier_on);
		carrier_mute_mode = 1'b1;
		pulse(mod_out_change);
		step(4);
		`CHK("carrier", 1'b1, carrier_on);
		for (i = 0; i < 3; i++) begin
			rts_action = 1'(i < 2);
			rts_req = i[0];
			step(6);
			`CHK("carrier", 1'(i > 0), carrier_on);
		end
		tx_mode = mdc_pkg::TX_BURST;
		for (i = 0; i < 4; i++) begin
			preamble_code = 2'(i);
			epl = (i == 0) ? mdc_pkg::PRE_LEN_32 :
				(i == 1) ? mdc_pkg::PRE_LEN_48 : mdc_pkg::PRE_LEN_64;
			pulse(mod_out_change);
			step(3);
			pulse(tx_start);
			step(1);
			`CHK("preamble", 1'b1, preamble_active);
			n = 0;
			while (preamble_active === 1'b1 && n < 100) begin
				pulse(tx_sym_tick);
				step(1);
				n++;
			end
			`CHK("pre_len", epl, 8'(n));
			step(2);
			`CHK("carrier", 1'b1, carrier_on);
		end
		end_sim();
	end
endmodule
